/* core/bal_regs.vh */
/*
 * Constants of the backlight, ambient sensor and regulator register bank.
 * This header assumes that it is included by its bare name, and only by the
 * design files under core/.
 */
// ============================================================
`ifndef BAL_REGS_VH
`define BAL_REGS_VH

// ============================================================
// Serial port
`define BAL_DEV_ADDR      7'h60
`define BAL_BYTE_BITS     4'h8

// ============================================================
// Register offsets
`define BAL_A_FLOOR       8'h02
`define BAL_A_FADE        8'h03
`define BAL_A_AFADE       8'h04
`define BAL_A_CFG         8'h05
`define BAL_A_BIAS        8'h06
`define BAL_A_GADJ        8'h07
`define BAL_A_AMB         8'h08
`define BAL_A_SLOT0       8'h09
`define BAL_A_SLOTF       8'h18
`define BAL_A_LDOAB       8'h19
`define BAL_A_LDOCD       8'h1A
`define BAL_A_LDOEN       8'h1B

// ============================================================
// Reset values
`define BAL_R_FLOOR       4'h0
`define BAL_R_FADE        8'h03
`define BAL_R_AFADE       8'h0B
`define BAL_R_CFG         8'h10
`define BAL_R_BIAS        8'h06
`define BAL_R_BYTE        8'h00
`define BAL_R_EN          4'h0

`endif

/* core/bal_i2c_edges.v */
/*
 * Edge and condition detector for the two-wire serial port.
 * Assumes scl and sdaIn are already synchronous to clk and that the bus
 * runs far slower than clk, so one sample per level is enough.
 */
`timescale 1ns/1ps
module bal_i2c_edges
(
    input  wire clk,
    input  wire rstN,
    input  wire scl,
    input  wire sdaIn,
    output wire sclRise,
    output wire sclFall,
    output wire startEv,
    output wire stopEv
);
    reg sclPrev_q;
    reg sdaPrev_q;

    // ============================================================
    // Previous levels
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else
        begin
            sclPrev_q <= scl;
            sdaPrev_q <= sdaIn;
        end
    end

    // A data change while the clock stays high frames a transfer.
    assign sclRise = scl & ~sclPrev_q;
    assign sclFall = ~scl & sclPrev_q;
    assign startEv = scl & sclPrev_q & sdaPrev_q & ~sdaIn;
    assign stopEv  = scl & sclPrev_q & ~sdaPrev_q & sdaIn;
endmodule // bal_i2c_edges

/* core/bal_slot_mem.v */
/*
 * Sixteen-entry store of backlight level slots with two registered reads.
 * Assumes one writer; both read ports give data one clock after the address.
 */
`timescale 1ns/1ps
module bal_slot_mem
#(
    parameter WIDTH = 7,
    parameter DEPTH = 16,
    parameter AW    = 4
)
(
    input  wire             clk,
    input  wire             rstN,
    input  wire             wrEn,
    input  wire [AW-1:0]    wrAddr,
    input  wire [WIDTH-1:0] wrData,
    input  wire [AW-1:0]    rdAddrA,
    output reg  [WIDTH-1:0] rdDataA,
    input  wire [AW-1:0]    rdAddrB,
    output reg  [WIDTH-1:0] rdDataB
);
    wire [WIDTH*DEPTH-1:0] flat;

    // ============================================================
    // Entries; each resets to zero, so the store is kept in flops.
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1)
        begin : gEntry
            localparam [AW-1:0] IDX = i;
            reg [WIDTH-1:0] slot_q;
            always @(posedge clk or negedge rstN)
            begin
                if (!rstN)
                    slot_q <= {WIDTH{1'b0}};
                else if (wrEn && wrAddr == IDX)
                    slot_q <= wrData;
            end
            assign flat[i*WIDTH +: WIDTH] = slot_q;
        end
    endgenerate

    // ============================================================
    // Registered read ports
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rdDataA <= {WIDTH{1'b0}};
            rdDataB <= {WIDTH{1'b0}};
        end
        else
        begin
            rdDataA <= flat[rdAddrA*WIDTH +: WIDTH];
            rdDataB <= flat[rdAddrB*WIDTH +: WIDTH];
        end
    end
endmodule // bal_slot_mem

/* core/bal_regbank.v */
/*
 * Register bank of the backlight, ambient sensor and regulator controller,
 * with its two-wire serial slave. The analog side reads the fields from
 * the outputs and feeds the ambient conversion result in.
 * Assumes scl and sdaIn are synchronous to clk and at least ten times
 * slower; the pad combines sdaOut and sdaOe into the open-drain line.
 */
`timescale 1ns/1ps
`include "bal_regs.vh"
module bal_regbank
#(
    parameter [6:0] DEV_ADDR = `BAL_DEV_ADDR
)
(
    input  wire       clk,
    input  wire       nrst,
    input  wire       scl,
    input  wire       sdaIn,
    output wire       sdaOut,
    output wire       sdaOe,
    input  wire [7:0] ambientResult,
    input  wire [3:0] slotIndex,
    output wire [6:0] levelSlotCurrent,
    output wire [3:0] fadeFloorCode,
    output wire [7:0] fadeControl,
    output wire [7:0] ambientFadeTime,
    output wire       pollingSelect,
    output wire [2:0] loadResistorSelect,
    output wire [1:0] ampGainMode,
    output wire       gainMethodSelect,
    output wire       ambientSenseEnable,
    output wire       offsetTestEnable,
    output wire [3:0] offsetCorrection,
    output wire [1:0] biasLevelSelect,
    output wire       biasOutputEnable,
    output wire [7:0] sensorGainAdjust,
    output wire [3:0] regulatorACode,
    output wire [3:0] regulatorBCode,
    output wire [3:0] regulatorCCode,
    output wire [3:0] regulatorDCode,
    output wire       regulatorAOn,
    output wire       regulatorBOn,
    output wire       regulatorCOn,
    output wire       regulatorDOn
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_PTR  = 3'h2;
    localparam [2:0] S_WDAT = 3'h3;
    localparam [2:0] S_SACK = 3'h4;
    localparam [2:0] S_RDAT = 3'h5;
    localparam [2:0] S_MACK = 3'h6;
    localparam [2:0] S_WAIT = 3'h7;

    reg  [1:0] rstSync_q;
    wire       rstN;
    wire       sclRise;
    wire       sclFall;
    wire       startEv;
    wire       stopEv;

    reg  [2:0] state_q;
    reg  [2:0] after_q;
    reg  [3:0] bitCnt_q;
    reg  [7:0] shift_q;
    reg  [7:0] ptr_q;
    reg        mackOk_q;
    reg        sdaOe_q;
    reg        sdaOut_q;

    reg  [3:0] floor_q;
    reg  [7:0] fade_q;
    reg  [7:0] afade_q;
    reg  [7:0] cfg_q;
    reg  [7:0] bias_q;
    reg  [7:0] gadj_q;
    reg  [7:0] amb_q;
    reg  [7:0] ldoAb_q;
    reg  [7:0] ldoCd_q;
    reg  [3:0] ldoEn_q;

    wire       byteDone;
    wire       wrEn;
    wire       inSlot;
    wire [7:0] slotOff;
    wire [6:0] memRd;
    reg  [7:0] readByte;

    // ============================================================
    // Reset release
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rstSync_q <= 2'b00;
        else
            rstSync_q <= {rstSync_q[0], 1'b1};
    end
    assign rstN = rstSync_q[1];

    // ============================================================
    // Bus conditions
    bal_i2c_edges uEdges
    (
        .clk     (clk),
        .rstN    (rstN),
        .scl     (scl),
        .sdaIn   (sdaIn),
        .sclRise (sclRise),
        .sclFall (sclFall),
        .startEv (startEv),
        .stopEv  (stopEv)
    );

    // ============================================================
    // Level slots
    assign slotOff = ptr_q - `BAL_A_SLOT0;
    assign inSlot  = (ptr_q >= `BAL_A_SLOT0) && (ptr_q <= `BAL_A_SLOTF);
    assign byteDone = sclFall && (bitCnt_q == `BAL_BYTE_BITS);
    assign wrEn     = byteDone && (state_q == S_WDAT);

    // Bit 7 of a slot is dropped on write and reads back as zero.
    bal_slot_mem #(.WIDTH(7), .DEPTH(16), .AW(4)) uSlots
    (
        .clk     (clk),
        .rstN    (rstN),
        .wrEn    (wrEn && inSlot),
        .wrAddr  (slotOff[3:0]),
        .wrData  (shift_q[6:0]),
        .rdAddrA (slotOff[3:0]),
        .rdDataA (memRd),
        .rdAddrB (slotIndex),
        .rdDataB (levelSlotCurrent)
    );

    // ============================================================
    // Read-back multiplexer
    always @*
    begin
        case (ptr_q)
            `BAL_A_FLOOR: readByte = {4'h0, floor_q};
            `BAL_A_FADE:  readByte = fade_q;
            `BAL_A_AFADE: readByte = afade_q;
            `BAL_A_CFG:   readByte = cfg_q;
            `BAL_A_BIAS:  readByte = bias_q;
            `BAL_A_GADJ:  readByte = gadj_q;
            `BAL_A_AMB:   readByte = amb_q;
            `BAL_A_LDOAB: readByte = ldoAb_q;
            `BAL_A_LDOCD: readByte = ldoCd_q;
            `BAL_A_LDOEN: readByte = {4'h0, ldoEn_q};
            default:      readByte = inSlot ? {1'b0, memRd} : 8'h00;
        endcase
    end

    // ============================================================
    // Ambient result capture
    // The result is re-sampled every clock so a read shows the latest
    // conversion; the bench compares all eight bits, in test mode too.
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            amb_q <= `BAL_R_BYTE;
        else
            amb_q <= ambientResult;
    end

    // ============================================================
    // Register writes
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            floor_q <= `BAL_R_FLOOR;
            fade_q  <= `BAL_R_FADE;
            afade_q <= `BAL_R_AFADE;
            cfg_q   <= `BAL_R_CFG;
            bias_q  <= `BAL_R_BIAS;
            gadj_q  <= `BAL_R_BYTE;
            ldoAb_q <= `BAL_R_BYTE;
            ldoCd_q <= `BAL_R_BYTE;
            ldoEn_q <= `BAL_R_EN;
        end
        else if (wrEn)
        begin
            case (ptr_q)
                `BAL_A_FLOOR: floor_q <= shift_q[3:0];
                `BAL_A_FADE:  fade_q  <= shift_q;
                `BAL_A_AFADE: afade_q <= shift_q;
                // Reserved resistor codes are kept as written.
                `BAL_A_CFG:   cfg_q   <= shift_q;
                `BAL_A_BIAS:  bias_q  <= shift_q;
                `BAL_A_GADJ:  gadj_q  <= shift_q;
                `BAL_A_LDOAB: ldoAb_q <= shift_q;
                `BAL_A_LDOCD: ldoCd_q <= shift_q;
                `BAL_A_LDOEN: ldoEn_q <= shift_q[3:0];
                default:      ldoEn_q <= ldoEn_q;
            endcase
        end
    end

    // ============================================================
    // Serial slave
    // No clock stretching: every answer is ready within one clk of the
    // falling scl edge, which the scl-to-clk ratio leaves ample room for.
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_q  <= S_IDLE;
            after_q  <= S_IDLE;
            bitCnt_q <= 4'h0;
            shift_q  <= 8'h00;
            ptr_q    <= 8'h00;
            mackOk_q <= 1'b0;
            sdaOe_q  <= 1'b0;
            sdaOut_q <= 1'b0;
        end
        else
        begin
            sdaOut_q <= 1'b0;
            if (startEv)
            begin
                state_q  <= S_ADDR;
                bitCnt_q <= 4'h0;
                sdaOe_q  <= 1'b0;
            end
            else if (stopEv)
            begin
                state_q <= S_IDLE;
                sdaOe_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    S_ADDR, S_PTR, S_WDAT:
                    begin
                        if (sclRise && bitCnt_q != `BAL_BYTE_BITS)
                        begin
                            shift_q  <= {shift_q[6:0], sdaIn};
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end
                        else if (byteDone)
                        begin
                            bitCnt_q <= 4'h0;
                            if (state_q == S_ADDR)
                            begin
                                if (shift_q[7:1] == DEV_ADDR)
                                begin
                                    sdaOe_q <= 1'b1;
                                    state_q <= S_SACK;
                                    after_q <= shift_q[0] ? S_RDAT : S_PTR;
                                end
                                else
                                    state_q <= S_WAIT;
                            end
                            else
                            begin
                                sdaOe_q <= 1'b1;
                                state_q <= S_SACK;
                                after_q <= S_WDAT;
                                if (state_q == S_PTR)
                                    ptr_q <= shift_q;
                                else
                                    ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                    S_SACK:
                    begin
                        if (sclFall)
                        begin
                            state_q <= after_q;
                            if (after_q == S_RDAT)
                            begin
                                shift_q  <= readByte;
                                sdaOe_q  <= ~readByte[7];
                                bitCnt_q <= 4'h1;
                            end
                            else
                            begin
                                sdaOe_q  <= 1'b0;
                                bitCnt_q <= 4'h0;
                            end
                        end
                    end
                    S_RDAT:
                    begin
                        if (byteDone)
                        begin
                            sdaOe_q <= 1'b0;
                            ptr_q   <= ptr_q + 8'h01;
                            state_q <= S_MACK;
                        end
                        else if (sclFall)
                        begin
                            shift_q  <= {shift_q[6:0], 1'b0};
                            sdaOe_q  <= ~shift_q[6];
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end
                    end
                    S_MACK:
                    begin
                        if (sclRise)
                            mackOk_q <= ~sdaIn;
                        else if (sclFall)
                        begin
                            if (mackOk_q)
                            begin
                                shift_q  <= readByte;
                                sdaOe_q  <= ~readByte[7];
                                bitCnt_q <= 4'h1;
                                state_q  <= S_RDAT;
                            end
                            else
                                state_q <= S_WAIT;
                        end
                    end
                    default:
                    begin
                        sdaOe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Field outputs
    assign sdaOut             = sdaOut_q;
    assign sdaOe              = sdaOe_q;
    assign fadeFloorCode      = floor_q;
    assign fadeControl        = fade_q;
    assign ambientFadeTime    = afade_q;
    assign pollingSelect      = cfg_q[7];
    assign loadResistorSelect = cfg_q[6:4];
    assign ampGainMode        = cfg_q[3:2];
    assign gainMethodSelect   = cfg_q[1];
    assign ambientSenseEnable = cfg_q[0];
    assign offsetTestEnable   = bias_q[7];
    assign offsetCorrection   = bias_q[6:3];
    assign biasLevelSelect    = bias_q[2:1];
    assign biasOutputEnable   = bias_q[0];
    assign sensorGainAdjust   = gadj_q;
    assign regulatorACode     = ldoAb_q[7:4];
    assign regulatorBCode     = ldoAb_q[3:0];
    assign regulatorCCode     = ldoCd_q[7:4];
    assign regulatorDCode     = ldoCd_q[3:0];
    assign regulatorDOn       = ldoEn_q[3];
    assign regulatorCOn       = ldoEn_q[2];
    assign regulatorBOn       = ldoEn_q[1];
    assign regulatorAOn       = ldoEn_q[0];
endmodule // bal_regbank

/* test/bal_i2c_host.sv */
/*
 * Two-wire host model driving scl and its share of the open-drain data line.
 * Assumes a pull-up on the data line and a device that never stretches scl.
 */
`timescale 1ns/1ps
module bal_i2c_host
#(
    parameter [6:0] DEV_ADDR = 7'h60
)
(
    input  wire  clk,
    input  wire  sdaOe,
    output logic scl,
    output wire  sdaIn
);
    logic hostLow;

    // ========================================
    // Wire level and bus phases
    // The pull-up wins only while neither party pulls the line low.
    assign sdaIn = !(hostLow || sdaOe);

    initial
    begin
        scl     = 1'h1;
        hostLow = 1'h0;
    end

    task automatic pause();
        repeat (5) @(negedge clk);
    endtask

    task automatic busStart();
        @(negedge clk) hostLow = 1'h0;
        pause();
        scl = 1'h1;
        pause();
        hostLow = 1'h1;
        pause();
        scl = 1'h0;
    endtask

    task automatic busStop();
        @(negedge clk) hostLow = 1'h1;
        pause();
        scl = 1'h1;
        pause();
        hostLow = 1'h0;
        pause();
    endtask

    // Data changes one clock after scl falls, so no edge looks like a START.
    task automatic bitXfer(input logic b, output logic r);
        @(negedge clk) hostLow = !b;
        pause();
        scl = 1'h1;
        pause();
        r   = sdaIn;
        scl = 1'h0;
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitXfer(b[i], r);
        end
        bitXfer(1'h1, r);
        ack = !r;
    endtask

    task automatic devSelect(input logic rd, output logic ack);
        sendByte({DEV_ADDR, rd}, ack);
    endtask

    task automatic recvByte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitXfer(1'h1, r);
            b[i] = r;
        end
        bitXfer(last, r);
    endtask
endmodule // bal_i2c_host

/* test/bal_regbank_props.sv */
/*
 * Port checker of the register bank.
 * Assumes the host holds each scl phase for five clocks or more.
 */
`timescale 1ns/1ps
module bal_regbank_props
(
    input wire       clk,
    input wire       nrst,
    input wire       scl,
    input wire       sdaOe,
    input wire [3:0] slotIndex,
    input wire [6:0] levelSlotCurrent,
    input wire [3:0] fadeFloorCode,
    input wire       pollingSelect,
    input wire [2:0] loadResistorSelect,
    input wire [1:0] ampGainMode,
    input wire       offsetTestEnable,
    input wire [3:0] offsetCorrection,
    input wire [3:0] regulatorACode,
    input wire [3:0] regulatorDCode,
    input wire       regulatorAOn
);
    logic       sclQ;
    logic [3:0] sinceFall;

    // ========================================
    // Clocks since the last scl fall
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclQ      <= 1'h1;
            sinceFall <= 4'hF;
        end
        else
        begin
            sclQ      <= scl;
            sinceFall <= (sclQ && !scl) ? 4'h0 :
                         (sinceFall == 4'hF) ? 4'hF : sinceFall + 4'h1;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);

    oe_rise_a: assert property ($rose(sdaOe) |-> !scl)
        else $error("data line pulled while scl high");
    oe_still_a: assert property (scl && $past(scl) |-> $stable(sdaOe))
        else $error("data line moved while scl high");
    oe_hold_a: assert property ($rose(sdaOe) |-> sdaOe [*8])
        else $error("data line released too early");
    cfg_change_a: assert property (
        !$stable({pollingSelect, loadResistorSelect, ampGainMode})
        |-> sinceFall < 4'h4) else $error("config moved off a write");
    bias_change_a: assert property (
        $changed({offsetTestEnable, offsetCorrection})
        |-> !scl && ($past(scl, 2) || $past(scl, 3) || $past(scl, 4)))
        else $error("bias moved off a write");
    floor_change_a: assert property (
        $changed(fadeFloorCode) |-> sinceFall <= 4'h3)
        else $error("floor code moved off a write");
    ldo_change_a: assert property (
        $changed({regulatorACode, regulatorDCode, regulatorAOn})
        |-> !scl && !$past(scl)) else $error("regulator moved off a write");
    slot_hold_a: assert property (
        scl && $past(scl) && $past(scl, 2) && $past(scl, 3)
        && $past(slotIndex, 2) == $past(slotIndex)
        |-> $stable(levelSlotCurrent)) else $error("slot output moved");

    cover property ($rose(sdaOe));
    cover property ($changed(loadResistorSelect));
    cover property ($changed(levelSlotCurrent));
endmodule // bal_regbank_props

bind bal_regbank bal_regbank_props u_props
(
    .clk, .nrst, .scl, .sdaOe, .slotIndex, .levelSlotCurrent,
    .fadeFloorCode, .pollingSelect, .loadResistorSelect, .ampGainMode,
    .offsetTestEnable, .offsetCorrection, .regulatorACode,
    .regulatorDCode, .regulatorAOn
);

/* test/bal_regbank_bench.sv */
/*
 * Self-checking bench of the register bank, driven through the host model.
 * Assumes the host model and the checker are compiled before this file.
 */
`timescale 1ns/1ps
module bal_regbank_bench;
    logic        clk;
    logic        nrst;
    logic [7:0]  ambientResult;
    logic [3:0]  slotIndex;
    wire         scl, sdaIn, sdaOut, sdaOe;
    wire  [6:0]  levelSlotCurrent;
    wire  [7:0]  fadeControl, ambientFadeTime, sensorGainAdjust;
    wire  [3:0]  fadeFloorCode, offsetCorrection;
    wire  [3:0]  regulatorACode, regulatorBCode, regulatorCCode;
    wire  [3:0]  regulatorDCode;
    wire  [2:0]  loadResistorSelect;
    wire  [1:0]  ampGainMode, biasLevelSelect;
    wire         pollingSelect, gainMethodSelect, ambientSenseEnable;
    wire         offsetTestEnable, biasOutputEnable;
    wire         regulatorAOn, regulatorBOn, regulatorCOn, regulatorDOn;
    int          n_errors;
    int          checks_done;
    logic [31:0] rng;
    logic [7:0]  img [0:31];
    logic [7:0]  expQ [$];
    string       nameQ [$];
    logic [7:0]  seenVal;
    event        seenEv;
    localparam logic [7:0] FIELD_A [9] = '{8'h02, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h07, 8'h19, 8'h1A, 8'h1B};

    bal_regbank uut (.clk, .nrst, .scl, .sdaIn, .sdaOut, .sdaOe,
        .ambientResult, .slotIndex, .levelSlotCurrent, .fadeFloorCode,
        .fadeControl, .ambientFadeTime, .pollingSelect, .loadResistorSelect,
        .ampGainMode, .gainMethodSelect, .ambientSenseEnable,
        .offsetTestEnable, .offsetCorrection, .biasLevelSelect,
        .biasOutputEnable, .sensorGainAdjust, .regulatorACode,
        .regulatorBCode, .regulatorCCode, .regulatorDCode, .regulatorAOn,
        .regulatorBOn, .regulatorCOn, .regulatorDOn);
    bal_i2c_host host (.clk, .sdaOe, .scl, .sdaIn);

    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // ========================================
    // Expectations and comparison
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [7:0] keepMask(input logic [7:0] a);
        if (a == 8'h02 || a == 8'h1B) return 8'h0F;
        if (a >= 8'h09 && a <= 8'h18) return 8'h7F;
        if (a >= 8'h03 && a <= 8'h1A && a != 8'h08) return 8'hFF;
        return 8'h00;
    endfunction

    function automatic logic [7:0] readExp(input logic [7:0] a);
        if (a == 8'h08) return ambientResult;
        return img[a[4:0]] & keepMask(a);
    endfunction

    function automatic logic [7:0] fieldImage(input logic [7:0] a);
        case (a)
            8'h02: return {4'h0, fadeFloorCode};
            8'h03: return fadeControl;
            8'h04: return ambientFadeTime;
            8'h05: return {pollingSelect, loadResistorSelect, ampGainMode,
                           gainMethodSelect, ambientSenseEnable};
            8'h06: return {offsetTestEnable, offsetCorrection,
                           biasLevelSelect, biasOutputEnable};
            8'h07: return sensorGainAdjust;
            8'h19: return {regulatorACode, regulatorBCode};
            8'h1A: return {regulatorCCode, regulatorDCode};
            8'h1B: return {4'h0, regulatorDOn, regulatorCOn, regulatorBOn,
                           regulatorAOn};
            default: return 8'h00;
        endcase
    endfunction

    task automatic compare(input string nm, input logic [7:0] seen,
                           input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    always @(seenEv)
    begin
        compare(nameQ.pop_front(), seenVal, expQ.pop_front());
    end

    task automatic expectOut(input string nm, input logic [7:0] seen,
                             input logic [7:0] exp);
        expQ.push_back(exp);
        nameQ.push_back(nm);
        seenVal = seen;
        -> seenEv;
        #1;
    endtask

    // ========================================
    // Bus transfers
    task automatic writeRegs(input logic [7:0] ptr, input int n);
        logic ack;
        logic allAck;
        host.busStart();
        host.devSelect(1'h0, allAck);
        host.sendByte(ptr, ack);
        allAck = allAck & ack;
        for (int i = 0; i < n; i++)
        begin
            host.sendByte(img[ptr[4:0] + i[4:0]], ack);
            allAck = allAck & ack;
        end
        host.busStop();
        expectOut("write ack", {7'h00, allAck}, 8'h01);
    endtask

    task automatic readRegs(input logic [7:0] ptr, input int n);
        logic       ack;
        logic [7:0] b;
        host.busStart();
        host.devSelect(1'h0, ack);
        host.sendByte(ptr, ack);
        host.busStart();
        host.devSelect(1'h1, ack);
        for (int i = 0; i < n; i++)
        begin
            host.recvByte(i == n - 1, b);
            expectOut("readback", b, readExp(ptr + i[7:0]));
        end
        host.busStop();
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial
    begin
        logic ack;
        nrst          = 1'h0;
        ambientResult = 8'h00;
        slotIndex     = 4'h0;
        rng           = 32'h0000_A355;
        n_errors      = 0;
        checks_done   = 0;
        foreach (img[a]) img[a] = 8'h00;
        img[3] = 8'h03;
        img[4] = 8'h0B;
        img[5] = 8'h10;
        img[6] = 8'h06;
        repeat (8) @(negedge clk);
        nrst = 1'h1;
        repeat (4) @(negedge clk);
        foreach (FIELD_A[k]) expectOut("reset", fieldImage(FIELD_A[k]),
            img[FIELD_A[k][4:0]]);
        expectOut("data drive", {7'h00, sdaOut}, 8'h00);
        readRegs(8'h00, 29);
        for (int a = 0; a < 29; a++)
        begin
            rng    = xorshift(rng);
            img[a] = rng[7:0];
        end
        ambientResult = rng[15:8];
        writeRegs(8'h00, 29);
        foreach (FIELD_A[k]) expectOut("field", fieldImage(FIELD_A[k]),
            readExp(FIELD_A[k]));
        for (int i = 0; i < 16; i++)
        begin
            @(negedge clk) slotIndex = i[3:0];
            repeat (2) @(negedge clk);
            expectOut("slot", {1'h0, levelSlotCurrent}, readExp(i + 9));
        end
        readRegs(8'h00, 29);
        for (int i = 0; i < 8; i++)
        begin
            img[5] = {i[0], i[2:0], i[1:0], ~i[0], i[1]};
            img[6] = {i[1], i[2:0], i[0], i[1:0], i[2]};
            writeRegs(8'h05, 2);
            expectOut("config", fieldImage(8'h05), img[5]);
            expectOut("bias", fieldImage(8'h06), img[6]);
        end
        // The last pass leaves offset test mode on; the read of 8'h08 still returns ambientResult.
        readRegs(8'h08, 1);
        host.busStart();
        host.sendByte({7'h61, 1'h0}, ack);
        expectOut("foreign ack", {7'h00, ack}, 8'h00);
        host.sendByte(8'h05, ack);
        host.sendByte(~img[5], ack);
        host.busStop();
        expectOut("ignored", fieldImage(8'h05), img[5]);
        stop_test();
    end
endmodule // bal_regbank_bench
